// File: core/hwcrc_map.vh
// register offsets, field positions, reset values and timing counts for hw config reset control
`ifndef HWCRC_MAP_VH
`define HWCRC_MAP_VH
// register word offsets (byte addresses)
`define HWCRC_OFS_CFG        8'h00
`define HWCRC_OFS_IRQ_STS    8'h04
`define HWCRC_OFS_IRQ_MASK   8'h08
`define HWCRC_OFS_STATE      8'h0C
// configuration register field positions
`define HWCRC_B_FULL_RST     0
`define HWCRC_B_LITE_RST     1
`define HWCRC_B_TO_SEL       3
`define HWCRC_B_PACKING      4
`define HWCRC_B_POLARITY     5
`define HWCRC_B_SEL_LO       6
`define HWCRC_B_SEL_HI       7
`define HWCRC_B_PROTECT      12
`define HWCRC_B_EMUL         13
`define HWCRC_B_DETACH_FLAG  15
`define HWCRC_B_LED0         20
`define HWCRC_B_LED1         21
// interrupt status bits
`define HWCRC_I_TIMEOUT      0
`define HWCRC_I_LITE_DONE    1
`define HWCRC_I_FULL_DONE    2
`define HWCRC_IRQ_W          3
// reset values of plain fields
`define HWCRC_RST_SEL        2'b00
`define HWCRC_RST_POL        1'b0
`define HWCRC_RST_LED        2'b00
// timing: clock period and time-outs
`define HWCRC_CLK_PS         20000
`define HWCRC_TO_LONG_US     30000
`define HWCRC_TO_SHORT_PS    1280000
`define HWCRC_TO_LONG_CYC    ((`HWCRC_TO_LONG_US * 1000) / (`HWCRC_CLK_PS / 1000))
`define HWCRC_TO_SHORT_CYC   (`HWCRC_TO_SHORT_PS / `HWCRC_CLK_PS)
// soft reset sequence lengths in cycles
`define HWCRC_LITE_CYC       16
`define HWCRC_FULL_CYC       64
`endif

// File: core/hwcrc_timeout.v
// eeprom response time-out counter with selectable length
`timescale 1ns/1ps
`default_nettype none
`include "hwcrc_map.vh"
module hwcrc_timeout #(
    parameter [20:0] LONG_CYC = `HWCRC_TO_LONG_CYC
) (
    input  wire        clock_in,      // system clock
    input  wire        rst_in,        // synchronous reset
    input  wire        start_in,      // begin waiting
    input  wire        respond_in,    // response seen, stop waiting
    input  wire        short_sel_in,  // 1 picks the short time-out
    output reg         expired_out    // one-cycle time-out pulse
);
    localparam [20:0] SHORT_CYC = `HWCRC_TO_SHORT_CYC;
    reg [20:0] count_r;   // cycles waited so far
    reg        busy_r;    // waiting for response
    wire [20:0] limit = short_sel_in ? SHORT_CYC : LONG_CYC;
    // ==========================================================
    // wait counter
    always @(posedge clock_in) begin
        if (rst_in) begin
            count_r     <= 21'h00_0000;
            busy_r      <= 1'b0;
            expired_out <= 1'b0;
        end else begin
            expired_out <= 1'b0;
            if (start_in) begin
                busy_r  <= 1'b1;
                count_r <= 21'h00_0000;
            end else if (busy_r && respond_in) begin
                busy_r <= 1'b0;
            end else if (busy_r) begin
                if (count_r + 21'h00_0001 >= limit) begin
                    busy_r      <= 1'b0;
                    expired_out <= 1'b1;
                end else begin
                    count_r <= count_r + 21'h00_0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: core/hwcrc_top.v
// hardware configuration and soft reset control register block
// Operation
// - polarity bit: 0 active low, 1 high
// - polarity applies regardless of emulation or eeprom
// - packing bit enables multi-frame usb packets
// - eeprom time-out 30 ms or 1.28 us
// - time-out sets flag in eeprom command register
// - lite reset bit self-clears after sequence
// - lite reset spares usb, phy, eeprom
// - full reset reloads eeprom, self-clears
// - phy disconnected during full reset
// - led enables default and restore from image
// - suspend select defaults and restores from image
// - polarity defaults and restores from image
// - detach flag set by detach event
// - polarity survives non-power-on resets when protected
// - protection shields select, polarity and led enables from non-power-on resets
// - select field chooses suspend states asserting pin
`timescale 1ns/1ps
`default_nettype none
`include "hwcrc_map.vh"
module hwcrc_top #(
    parameter [20:0] LONG_CYC = `HWCRC_TO_LONG_CYC  // long eeprom time-out in cycles
) (
    input  wire        clock_in,          // 50 mhz system clock
    input  wire        rst_in,            // power-on reset, synchronous
    input  wire [7:0]  addr_in,           // register byte address
    input  wire [31:0] wdata_in,          // write data
    input  wire        wr_in,             // write strobe
    input  wire        rd_in,             // read strobe
    output reg  [31:0] rdata_out,         // read data, cycle after strobe
    input  wire        usb_reset_in,      // usb bus reset pulse
    input  wire        image_valid_in,    // eeprom or otp image loaded
    input  wire [1:0]  image_sel_in,      // stored suspend select
    input  wire        image_pol_in,      // stored suspend polarity
    input  wire [1:0]  image_led_in,      // stored led enables
    input  wire        deep_suspend_in,   // deepest clock-stopped state
    input  wire        light_suspend_in,  // light suspend state
    input  wire        lightest_suspend_in, // lightest suspend state
    input  wire        unpowered_wait_in, // unpowered wait state
    input  wire        detached_in,       // device detached from usb
    input  wire        detach_event_in,   // link-driven detach event pulse
    input  wire        eeprom_start_in,   // eeprom access begins
    input  wire        eeprom_resp_in,    // eeprom responded
    output reg         suspend_pin_out,   // suspend indicator pin
    output reg         multi_frame_packing_out, // tx packing enable
    output reg [1:0]   led_pin_enable_out,      // led pin enables
    output reg         eeprom_timeout_flag_out, // flag in eeprom command register
    output reg         lite_reset_out,    // lite reset to non-usb logic
    output reg         full_reset_out,    // full reset to device logic
    output reg         eeprom_reload_out, // request eeprom reload
    output reg         phy_disconnect_out, // hold usb phy disconnected
    output reg         irq_out            // level interrupt
);
    // ==========================================================
    // state and constants
    localparam [1:0] ST_IDLE = 2'b00;     // no soft reset
    localparam [1:0] ST_LITE = 2'b01;     // lite reset sequence
    localparam [1:0] ST_FULL = 2'b10;     // full reset sequence
    localparam [6:0] LITE_CYC = `HWCRC_LITE_CYC;
    localparam [6:0] FULL_CYC = `HWCRC_FULL_CYC;

    reg  [1:0] state_r;                   // soft reset state
    reg  [6:0] seq_cnt_r;                 // sequence cycle counter
    reg        polarity_r;                // suspend_pin_polarity
    reg  [1:0] select_r;                  // suspend select field
    reg        packing_r;                 // multi_frame_packing
    reg        to_sel_r;                  // eeprom_timeout_select
    reg        protect_r;                 // reset protection
    reg        emul_r;                    // descriptor_emulation_enable
    reg  [1:0] led_r;                     // led_pin_enable
    reg        detach_flag_r;             // detach_event_flag
    reg  [`HWCRC_IRQ_W-1:0] irq_sts_r;    // sticky event bits
    reg  [`HWCRC_IRQ_W-1:0] irq_mask_r;   // interrupt enables
    reg        timeout_flag_r;            // eeprom timeout flag
    reg        usb_rst_s1_r;              // usb reset synchroniser
    reg        usb_rst_s2_r;
    reg        det_s1_r;                  // detach event synchroniser
    reg        det_s2_r;
    reg        det_s3_r;                  // edge history
    reg  [3:0] susp_s1_r;                 // suspend state synchroniser
    reg  [3:0] susp_s2_r;
    reg        detached_s1_r;
    reg        detached_s2_r;
    reg        resp_s1_r;                 // eeprom response synchroniser
    reg        resp_s2_r;
    wire       to_pulse;                  // time-out event

    // ==========================================================
    // input synchronisers
    always @(posedge clock_in) begin
        if (rst_in) begin
            usb_rst_s1_r  <= 1'b0;
            usb_rst_s2_r  <= 1'b0;
            det_s1_r      <= 1'b0;
            det_s2_r      <= 1'b0;
            det_s3_r      <= 1'b0;
            susp_s1_r     <= 4'h0;
            susp_s2_r     <= 4'h0;
            detached_s1_r <= 1'b0;
            detached_s2_r <= 1'b0;
            resp_s1_r     <= 1'b0;
            resp_s2_r     <= 1'b0;
        end else begin
            usb_rst_s1_r  <= usb_reset_in;
            usb_rst_s2_r  <= usb_rst_s1_r;
            det_s1_r      <= detach_event_in;
            det_s2_r      <= det_s1_r;
            det_s3_r      <= det_s2_r;
            susp_s1_r     <= {unpowered_wait_in, lightest_suspend_in,
                              light_suspend_in, deep_suspend_in};
            susp_s2_r     <= susp_s1_r;
            detached_s1_r <= detached_in;
            detached_s2_r <= detached_s1_r;
            resp_s1_r     <= eeprom_resp_in;
            resp_s2_r     <= resp_s1_r;
        end
    end

    // ==========================================================
    // eeprom time-out counter
    hwcrc_timeout #(.LONG_CYC(LONG_CYC)) u_timeout (
        .clock_in     (clock_in),
        .rst_in       (rst_in),
        .start_in     (eeprom_start_in),
        .respond_in   (resp_s2_r),
        .short_sel_in (to_sel_r),
        .expired_out  (to_pulse)
    );

    // decoded bus accesses
    wire wr_cfg  = wr_in && (addr_in == `HWCRC_OFS_CFG);
    wire wr_sts  = wr_in && (addr_in == `HWCRC_OFS_IRQ_STS);
    wire wr_mask = wr_in && (addr_in == `HWCRC_OFS_IRQ_MASK);
    wire usb_rst_rise = usb_rst_s2_r;     // level held reset
    wire det_rise     = det_s2_r & ~det_s3_r;
    // image value or zero when no image
    wire [1:0] img_sel = image_valid_in ? image_sel_in : `HWCRC_RST_SEL;
    wire       img_pol = image_valid_in ? image_pol_in : `HWCRC_RST_POL;
    wire [1:0] img_led = image_valid_in ? image_led_in : `HWCRC_RST_LED;
    // restore request from usb reset, lite reset entry or full reset entry
    wire restore = usb_rst_rise | (state_r == ST_LITE && seq_cnt_r == 7'h00)
                 | (state_r == ST_FULL && seq_cnt_r == 7'h00);
    wire seq_done = (seq_cnt_r == LITE_CYC - 7'h01 && state_r == ST_LITE)
                  | (seq_cnt_r == FULL_CYC - 7'h01 && state_r == ST_FULL);
    wire [`HWCRC_IRQ_W-1:0] ev = {seq_done && state_r == ST_FULL,
                                  seq_done && state_r == ST_LITE, to_pulse};

    // ==========================================================
    // soft reset sequencer
    always @(posedge clock_in) begin
        if (rst_in) begin
            state_r   <= ST_IDLE;
            seq_cnt_r <= 7'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    seq_cnt_r <= 7'h00;
                    if (wr_cfg && wdata_in[`HWCRC_B_FULL_RST])
                        state_r <= ST_FULL;
                    else if (wr_cfg && wdata_in[`HWCRC_B_LITE_RST])
                        state_r <= ST_LITE;
                end
                ST_LITE, ST_FULL: begin
                    if (seq_done) begin
                        state_r   <= ST_IDLE;
                        seq_cnt_r <= 7'h00;
                    end else begin
                        seq_cnt_r <= seq_cnt_r + 7'h01;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // configuration fields
    always @(posedge clock_in) begin
        if (rst_in) begin
            polarity_r <= `HWCRC_RST_POL;
            select_r   <= `HWCRC_RST_SEL;
            led_r      <= `HWCRC_RST_LED;
            packing_r  <= 1'b0;
            to_sel_r   <= 1'b0;
            protect_r  <= 1'b0;
            emul_r     <= 1'b0;
        end else if (restore && !protect_r) begin
            polarity_r <= img_pol;
            select_r   <= img_sel;
            led_r      <= img_led;
            if (state_r == ST_FULL) begin
                packing_r <= 1'b0;
                to_sel_r  <= 1'b0;
            end
        end else if (restore && state_r == ST_FULL) begin
            packing_r <= 1'b0;
            to_sel_r  <= 1'b0;
        end else if (wr_cfg) begin
            polarity_r <= wdata_in[`HWCRC_B_POLARITY];
            select_r   <= wdata_in[`HWCRC_B_SEL_HI:`HWCRC_B_SEL_LO];
            packing_r  <= wdata_in[`HWCRC_B_PACKING];
            to_sel_r   <= wdata_in[`HWCRC_B_TO_SEL];
            protect_r  <= wdata_in[`HWCRC_B_PROTECT];
            emul_r     <= wdata_in[`HWCRC_B_EMUL];
            led_r      <= {wdata_in[`HWCRC_B_LED1], wdata_in[`HWCRC_B_LED0]};
        end
    end

    // ==========================================================
    // flags and interrupts, set wins over clear
    always @(posedge clock_in) begin
        if (rst_in) begin
            detach_flag_r  <= 1'b0;
            timeout_flag_r <= 1'b0;
            irq_sts_r      <= {`HWCRC_IRQ_W{1'b0}};
            irq_mask_r     <= {`HWCRC_IRQ_W{1'b0}};
        end else begin
            if (det_rise)
                detach_flag_r <= 1'b1;
            else if (wr_cfg && wdata_in[`HWCRC_B_DETACH_FLAG])
                detach_flag_r <= 1'b0;
            if (to_pulse)
                timeout_flag_r <= 1'b1;
            else if (eeprom_start_in)
                timeout_flag_r <= 1'b0;
            irq_sts_r <= ev | (irq_sts_r & ~(wr_sts ? wdata_in[`HWCRC_IRQ_W-1:0]
                                                    : {`HWCRC_IRQ_W{1'b0}}));
            if (wr_mask)
                irq_mask_r <= wdata_in[`HWCRC_IRQ_W-1:0];
        end
    end

    // ==========================================================
    // suspend condition decode by select field
    reg susp_cond;
    always @* begin
        case (select_r)
            2'b00:   susp_cond = susp_s2_r[0];
            2'b01:   susp_cond = susp_s2_r[0] | susp_s2_r[1] | detached_s2_r;
            2'b10:   susp_cond = |susp_s2_r[2:0] | detached_s2_r;
            default: susp_cond = |susp_s2_r | detached_s2_r;
        endcase
    end

    // ==========================================================
    // registered outputs and read data
    always @(posedge clock_in) begin
        if (rst_in) begin
            suspend_pin_out         <= 1'b1;
            multi_frame_packing_out <= 1'b0;
            led_pin_enable_out      <= 2'b00;
            eeprom_timeout_flag_out <= 1'b0;
            lite_reset_out          <= 1'b0;
            full_reset_out          <= 1'b0;
            eeprom_reload_out       <= 1'b0;
            phy_disconnect_out      <= 1'b0;
            irq_out                 <= 1'b0;
            rdata_out               <= 32'h0000_0000;
        end else begin
            // active low when polarity 0, active high when 1
            suspend_pin_out         <= ~(susp_cond ^ polarity_r);
            multi_frame_packing_out <= packing_r;
            led_pin_enable_out      <= led_r;
            eeprom_timeout_flag_out <= timeout_flag_r;
            // lite reset leaves usb, phy and eeprom alone
            lite_reset_out          <= (state_r == ST_LITE);
            full_reset_out          <= (state_r == ST_FULL);
            eeprom_reload_out       <= (state_r == ST_FULL) && seq_done;
            phy_disconnect_out      <= (state_r == ST_FULL) && !seq_done;
            irq_out                 <= |(irq_sts_r & irq_mask_r);
            rdata_out               <= 32'h0000_0000;
            if (rd_in) begin
                case (addr_in)
                    `HWCRC_OFS_CFG: begin
                        rdata_out[`HWCRC_B_FULL_RST]    <= (state_r == ST_FULL);
                        rdata_out[`HWCRC_B_LITE_RST]    <= (state_r == ST_LITE);
                        rdata_out[`HWCRC_B_TO_SEL]      <= to_sel_r;
                        rdata_out[`HWCRC_B_PACKING]     <= packing_r;
                        rdata_out[`HWCRC_B_POLARITY]    <= polarity_r;
                        rdata_out[`HWCRC_B_SEL_HI:`HWCRC_B_SEL_LO] <= select_r;
                        rdata_out[`HWCRC_B_PROTECT]     <= protect_r;
                        rdata_out[`HWCRC_B_EMUL]        <= emul_r;
                        rdata_out[`HWCRC_B_DETACH_FLAG] <= detach_flag_r;
                        rdata_out[`HWCRC_B_LED1]        <= led_r[1];
                        rdata_out[`HWCRC_B_LED0]        <= led_r[0];
                    end
                    `HWCRC_OFS_IRQ_STS:  rdata_out[`HWCRC_IRQ_W-1:0] <= irq_sts_r;
                    `HWCRC_OFS_IRQ_MASK: rdata_out[`HWCRC_IRQ_W-1:0] <= irq_mask_r;
                    `HWCRC_OFS_STATE: begin
                        rdata_out[1:0]  <= state_r;
                        rdata_out[2]    <= timeout_flag_r;
                        rdata_out[3]    <= susp_cond;
                    end
                    default: rdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/hwcrc_asserts.sv
// port checks for hw config reset control
`timescale 1ns/1ps
`default_nettype none
`include "hwcrc_map.vh"
module hwcrc_asserts (
    input wire logic        clock_in,
    input wire logic        rst_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic        eeprom_start_in,
    input wire logic        suspend_pin_out,
    input wire logic        eeprom_timeout_flag_out,
    input wire logic        lite_reset_out,
    input wire logic        full_reset_out,
    input wire logic        eeprom_reload_out,
    input wire logic        phy_disconnect_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // ==========
    // soft reset run lengths
    logic [7:0] full_run_r;  // full reset high edges
    logic [7:0] lite_run_r;  // lite reset high edges
    always_ff @(posedge clock_in) begin
        full_run_r <= (rst_in || !full_reset_out) ? 8'h00 : full_run_r + 8'h01;
        lite_run_r <= (rst_in || !lite_reset_out) ? 8'h00 : lite_run_r + 8'h01;
    end
    // ==========
    // sequences, properties
    sequence s_full_end;
        $fell(full_reset_out) && !$past(rst_in);
    endsequence
    sequence s_reload_pulse;
        eeprom_reload_out ##1 !eeprom_reload_out;
    endsequence
    property p_full_len;
        s_full_end |-> full_run_r == `HWCRC_FULL_CYC;
    endproperty
    property p_lite_len;
        $fell(lite_reset_out) && !$past(rst_in) |-> lite_run_r == `HWCRC_LITE_CYC;
    endproperty
    property p_reload_pulse;
        eeprom_reload_out |-> (full_reset_out || $past(full_reset_out)) and s_reload_pulse;
    endproperty
    property p_phy_in_full;
        phy_disconnect_out |-> full_reset_out;
    endproperty
    property p_phy_release;
        $fell(phy_disconnect_out) && !$past(rst_in) |-> full_reset_out ##1 !full_reset_out;
    endproperty
    property p_lite_spares;
        lite_reset_out && !full_reset_out |-> !phy_disconnect_out && !eeprom_reload_out;
    endproperty
    property p_start_clears;
        eeprom_start_in |-> ##2 !eeprom_timeout_flag_out;
    endproperty
    property p_rdata_idle;
        !rd_in |=> rdata_out == 32'h0000_0000;
    endproperty
    property p_reset_vals;
        disable iff (1'b0) rst_in |=> suspend_pin_out && !irq_out && !full_reset_out;
    endproperty
    a_full_len: assert property (p_full_len) else $error("full length wrong");
    a_lite_len: assert property (p_lite_len) else $error("lite length wrong");
    a_reload_pulse: assert property (p_reload_pulse) else $error("reload pulse bad");
    a_phy_in_full: assert property (p_phy_in_full) else $error("phy off outside full");
    a_phy_release: assert property (p_phy_release) else $error("phy back too soon");
    a_lite_spares: assert property (p_lite_spares) else $error("lite touched phy");
    a_start_clears: assert property (p_start_clears) else $error("flag not cleared");
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle");
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
endmodule
bind hwcrc_top hwcrc_asserts hwcrc_asserts_i (.clock_in, .rst_in, .rd_in, .rdata_out,
    .eeprom_start_in, .suspend_pin_out, .eeprom_timeout_flag_out, .lite_reset_out,
    .full_reset_out, .eeprom_reload_out, .phy_disconnect_out, .irq_out);
`default_nettype wire

// File: tb/tb_hw_config_reset_control.sv
// self-checking bench for hw config reset control
`timescale 1ns/1ps
`default_nettype none
`include "hwcrc_map.vh"
module tb_hw_config_reset_control;
    localparam integer LONG = 200;  // shortened long time-out
    logic        clock_in, rst_in, wr_in, rd_in, usb_reset_in, image_valid_in, image_pol_in;
    logic        deep_suspend_in, light_suspend_in, lightest_suspend_in, unpowered_wait_in;
    logic        detached_in, detach_event_in, eeprom_start_in, eeprom_resp_in;
    logic [7:0]  addr_in;
    logic [31:0] wdata_in;
    logic [1:0]  image_sel_in, image_led_in;
    wire  [31:0] rdata_out;
    wire         suspend_pin_out, multi_frame_packing_out, eeprom_timeout_flag_out;
    wire         lite_reset_out, full_reset_out, eeprom_reload_out, phy_disconnect_out, irq_out;
    wire  [1:0]  led_pin_enable_out;
    integer      err_count = 0, cmp_count = 0, n, i;
    logic [15:0] lf = 16'h62c8;        // lfsr state
    logic [31:0] cfg_m = 32'h0000_0000; // config model
    logic [31:0] r;                    // last read data
    logic        cnd, seen_phy, seen_rl;
    hwcrc_top #(.LONG_CYC(LONG)) hwcrc_top_i (.*);
    always #10 clock_in = ~clock_in;
    // ==========
    // helpers
    function automatic [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string nm, input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input [7:0] a, input [31:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input [7:0] a);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 r = rdata_out;
    endtask
    task automatic usb_pulse(input logic p);
        cfg_m[12] = p;
        wr(`HWCRC_OFS_CFG, cfg_m);
        @(posedge clock_in);
        usb_reset_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        usb_reset_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        rd(`HWCRC_OFS_CFG);
    endtask
    // time-out run, answer after ten cycles if asked
    task automatic to_run(input logic sel, input logic resp);
        cfg_m[3] = sel;
        wr(`HWCRC_OFS_CFG, cfg_m);
        @(posedge clock_in);
        eeprom_start_in <= 1'b1;
        @(posedge clock_in);
        eeprom_start_in <= 1'b0;
        for (n = 1; n < 400; n++) begin
            @(posedge clock_in);
            eeprom_resp_in <= resp && n >= 10 && n < 14;
            #1;
            if (eeprom_timeout_flag_out === 1'b1) break;
        end
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ==========
    // main sequence
    initial begin
        {clock_in, wr_in, rd_in, usb_reset_in, image_valid_in, deep_suspend_in} = 6'h00;
        {light_suspend_in, lightest_suspend_in, unpowered_wait_in, detached_in} = 4'h0;
        {detach_event_in, eeprom_start_in, eeprom_resp_in, addr_in, wdata_in} = 43'h0;
        {rst_in, image_pol_in, image_sel_in, image_led_in} = 6'h2d;
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
        // power-on values, image not loaded
        chk("pin reset", suspend_pin_out, 1);
        rd(`HWCRC_OFS_CFG);
        chk("led reset", r[21:20], 0);
        chk("sel reset", r[7:6], 0);
        chk("pol reset", r[5], 0);
        chk("pack reset", r[4], 0);
        cfg_m = 32'h0000_0010;
        wr(`HWCRC_OFS_CFG, cfg_m);
        wr(8'h10, 32'hffff_ffff);
        rd(8'h10);
        chk("unmapped", r, 0);
        rd(`HWCRC_OFS_CFG);
        chk("pack bit", r[4], 1);
        chk("pack out", multi_frame_packing_out, 1);
        $display("test registers done");
        // suspend pin over select, polarity, emulation
        for (i = 0; i < 16; i++) begin
            lf = lfsr(lf);
            cfg_m[7:5] = {i[1:0], i[2]};
            cfg_m[13] = i[3];
            wr(`HWCRC_OFS_CFG, cfg_m);
            {deep_suspend_in, light_suspend_in, lightest_suspend_in} <= lf[4:2];
            {unpowered_wait_in, detached_in} <= lf[1:0];
            repeat (6) @(posedge clock_in);
            #1 cnd = lf[4] | (i[1:0] != 0 && (lf[3] | lf[0])) | (i[1:0] > 1 && lf[2]);
            cnd |= i[1:0] == 3 && lf[1];
            chk("pin", suspend_pin_out, i[2] ? cnd : !cnd);
        end
        cfg_m[5] = 1'b0;
        wr(`HWCRC_OFS_CFG, cfg_m);
        @(posedge clock_in);
        #1 chk("pin next cycle", suspend_pin_out, !cnd);
        $display("test suspend pin done");
        // lite reset restores image, raises irq
        image_valid_in <= 1'b1;
        cfg_m[7:5] = 3'h1;
        wr(`HWCRC_OFS_CFG, cfg_m | 32'h0000_0002);
        rd(`HWCRC_OFS_CFG);
        chk("lite bit set", r[1], 1);
        seen_phy = 1'b0;
        for (n = 0; n < 100 && lite_reset_out === 1'b1; n++) begin
            @(posedge clock_in);
            #1 seen_phy |= phy_disconnect_out | eeprom_reload_out;
        end
        chk("lite end", n < 100, 1);
        if (n == 100) final_report();
        chk("lite spares phy", seen_phy, 0);
        rd(`HWCRC_OFS_CFG);
        chk("lite bit clear", r[1], 0);
        chk("led image", r[21:20], image_led_in);
        chk("led out", led_pin_enable_out, image_led_in);
        chk("sel image", r[7:6], image_sel_in);
        chk("pol image", r[5], image_pol_in);
        rd(`HWCRC_OFS_IRQ_STS);
        chk("lite done", r[`HWCRC_I_LITE_DONE], 1);
        chk("irq masked", irq_out, 0);
        wr(`HWCRC_OFS_IRQ_MASK, 32'h0000_0007);
        repeat (2) @(posedge clock_in);
        #1 chk("irq high", irq_out, 1);
        wr(`HWCRC_OFS_IRQ_STS, 32'h0000_0002);
        repeat (2) @(posedge clock_in);
        #1 chk("irq cleared", irq_out, 0);
        $display("test lite reset done");
        // protection against usb reset
        cfg_m[7:5] = {~image_sel_in, ~image_pol_in};
        usb_pulse(1'b1);
        chk("protected", r[7:5], cfg_m[7:5]);
        usb_pulse(1'b0);
        chk("usb restore", r[7:5], {image_sel_in, image_pol_in});
        $display("test protection done");
        // full reset: phy off, eeprom reload
        wr(`HWCRC_OFS_CFG, cfg_m | 32'h0000_0001);
        {seen_phy, seen_rl} = 2'h0;
        for (n = 0; n < 200; n++) begin
            @(posedge clock_in);
            #1 seen_phy |= phy_disconnect_out;
            seen_rl |= eeprom_reload_out;
            if (n > 4 && full_reset_out === 1'b0) break;
        end
        chk("full end", n < 200, 1);
        if (n == 200) final_report();
        chk("phy held off", seen_phy, 1);
        chk("reload seen", seen_rl, 1);
        chk("pack cleared", multi_frame_packing_out, 0);
        rd(`HWCRC_OFS_CFG);
        chk("full bit clear", r[0], 0);
        cfg_m[4] = 1'b0;
        $display("test full reset done");
        // time-outs: short, long, answered
        to_run(1'b1, 1'b0);
        chk("short timeout", n >= 62 && n <= 68, 1);
        rd(`HWCRC_OFS_STATE);
        chk("flag in state", r[2], 1);
        to_run(1'b0, 1'b0);
        chk("long timeout", n >= LONG - 2 && n <= LONG + 4, 1);
        to_run(1'b1, 1'b1);
        chk("answered", eeprom_timeout_flag_out, 0);
        rd(`HWCRC_OFS_IRQ_STS);
        chk("timeout irq", r[`HWCRC_I_TIMEOUT], 1);
        $display("test timeout done");
        // detach event flag, cleared by writing one
        @(posedge clock_in);
        detach_event_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        detach_event_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        rd(`HWCRC_OFS_CFG);
        chk("detach set", r[15], 1);
        wr(`HWCRC_OFS_CFG, cfg_m | 32'h0000_8000);
        rd(`HWCRC_OFS_CFG);
        chk("detach clear", r[15], 0);
        $display("test detach done");
        final_report();
    end
endmodule
`default_nettype wire
